/* logic/sdp_pkg.sv */
package sdp_pkg;
    // ------------------------------------------------------------------
    // Register map of the debug status and control view.
    // ------------------------------------------------------------------
    localparam logic [3:0]  ADDR_STATUS_CTRL = 4'h0;   // Debug status and control.
    localparam logic [3:0]  ADDR_SECURE_USER = 4'h4;   // Secure-user enable bits.
    localparam logic [3:0]  ADDR_CPU_STATE   = 4'h8;   // Core state and permission view.
    localparam logic [3:0]  ADDR_EVENT       = 4'hc;   // Last event outcome.

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int MODE_SEL_LSB    = 14;   // Debug-mode select field, bits 15:14.
    localparam int SPI_VIEW_BIT    = 16;   // Sampled secure invasive enable.
    localparam int SPNI_VIEW_BIT   = 17;   // Sampled secure non-invasive enable.
    localparam int SUI_BIT         = 0;    // Secure-user invasive bit.
    localparam int SUNI_BIT        = 1;    // Secure-user non-invasive bit.

    // ------------------------------------------------------------------
    // Reset values and encodings.
    // ------------------------------------------------------------------
    localparam logic [1:0]  MODE_SEL_RST   = 2'h0;   // No debug-mode after reset.
    localparam logic [1:0]  SU_BITS_RST    = 2'h0;   // Secure-user bits clear.
    localparam logic [1:0]  MODE_MONITOR   = 2'h2;   // Monitor encoding.
    localparam logic [4:0]  CPU_MODE_USER  = 5'h10;  // User mode code.
    localparam logic [4:0]  CPU_MODE_MON   = 5'h16;  // Secure Monitor mode code.
    localparam int          SYNC_STAGES    = 2;      // Enable synchroniser depth.

    // Outcome of a debug event.
    typedef enum logic [3:0] {
        SDP_ACT_NONE    = 4'h1,
        SDP_ACT_HALT    = 4'h2,
        SDP_ACT_EXCEPT  = 4'h4,
        SDP_ACT_PABORT  = 4'h8
    } sdp_action_t;
endpackage

/* logic/sdp_perm_if.sv */
interface sdp_perm_if;
    logic       dbg_en;        // Synchronised global debug enable.
    logic       spi_en;        // Synchronised secure invasive enable.
    logic       spni_en;       // Synchronised secure non-invasive enable.
    logic       sui_bit;       // Secure-user invasive bit.
    logic       suni_bit;      // Secure-user non-invasive bit.
    logic       ns_bit;        // Non-secure state bit.
    logic [4:0] cpu_mode;      // Current processor mode.
    logic       inv_ok;        // Invasive debug permitted.
    logic       noninv_ok;     // Non-invasive debug permitted.
    logic       restricted;    // Permission only through the secure-user bit.

    modport core (input dbg_en, spi_en, spni_en, sui_bit, suni_bit, ns_bit, cpu_mode,
                  output inv_ok, noninv_ok, restricted);
    modport user (output dbg_en, spi_en, spni_en, sui_bit, suni_bit, ns_bit, cpu_mode,
                  input inv_ok, noninv_ok, restricted);
endinterface

/* logic/sdp_sync.sv */
module sdp_sync (
    input  wire logic       clk_i,      // Core clock.
    input  wire logic       rst_n_i,    // Asynchronous reset, active low.
    input  wire logic [2:0] async_i,    // Enable pins from the security controller.
    output logic      [2:0] sync_o      // Enables in the core clock domain.
);
    // ------------------------------------------------------------------
    // Two-flop synchronisers; the first stage feeds only the second.
    // ------------------------------------------------------------------
    logic [2:0] meta_reg;
    logic [2:0] meta_next;
    logic [2:0] sync_reg;
    logic [2:0] sync_next;

    // Next values simply shift one stage.
    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    // Pins may change at any time, running or halted, so they are always resampled.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;
endmodule

/* logic/sdp_perm.sv */
module sdp_perm (
    sdp_perm_if.core p    // Permission inputs and verdicts.
);
    // ------------------------------------------------------------------
    // Permission decode for the current security state and mode.
    // ------------------------------------------------------------------
    logic secure_user;
    logic secure_priv;
    logic is_monitor;

    // Decode the security context, then grant per kind of debug.
    always_comb begin
        is_monitor  = (p.cpu_mode == sdp_pkg::CPU_MODE_MON);
        secure_user = !p.ns_bit && (p.cpu_mode == sdp_pkg::CPU_MODE_USER);
        secure_priv = (!p.ns_bit || is_monitor) && !secure_user;
        p.inv_ok    = 1'b0;
        p.noninv_ok = 1'b0;
        p.restricted = 1'b0;
        if (p.dbg_en) begin
            if (p.spi_en) begin
                p.inv_ok = 1'b1;
            end else if (secure_priv) begin
                p.inv_ok = 1'b0;
            end else if (secure_user) begin
                p.inv_ok     = p.sui_bit;
                p.restricted = p.sui_bit;
            end else begin
                p.inv_ok = 1'b1;
            end
            if (p.spni_en || !(secure_priv || secure_user)) begin
                p.noninv_ok = 1'b1;
            end else if (secure_user) begin
                p.noninv_ok = p.suni_bit;
            end
        end
    end
endmodule

/* logic/sdp_top.sv */
// How it works
// - Secure invasive pin high permits all Secure modes.
// - Pin low: Secure user only by user bit.
// - Secure non-invasive pin high permits all Secure.
// - Pin low: non-invasive user by user bit.
// - Global enable low disables all; field reads zero.
// - Selected mode applies everywhere when both enabled.
// - User bit clear: only Non-secure, not Monitor.
// - User bit set: add Secure User mode.
// - Halting through user bit gives restricted capability.
// - No mode: only breakpoint, request, halt act.
// - Unpermitted keeps mode selection, suppresses effect.
// - Debug exceptions are handled in privileged mode.
// - Enables may change while running or halted.
// - Status shows sampled secure enable views.
// - Global enable seen only via field readback.
// - Request or halt enters debug when permitted.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
module sdp_top (
    input  wire logic        clk_i,                       // Core clock, 40 MHz.
    input  wire logic        rst_n_i,                     // Asynchronous reset, active low.
    input  wire logic        global_debug_en_i,           // Global debug enable pin.
    input  wire logic        secure_priv_invasive_en_i,   // Secure invasive enable pin.
    input  wire logic        secure_priv_noninvasive_en_i,// Secure non-invasive enable pin.
    input  wire logic        nonsecure_state_bit_i,       // Core is in Non-secure state.
    input  wire logic [4:0]  cpu_mode_i,                  // Current processor mode.
    input  wire logic        sw_event_i,                  // Software debug event pulse.
    input  wire logic        breakpoint_instruction_i,    // Breakpoint instruction committed.
    input  wire logic        ext_debug_req_i,             // External debug request level.
    input  wire logic        debug_scan_port_halt_i,      // Halt from debug scan port pulse.
    input  wire logic        debug_exit_i,                // Leave debug state pulse.
    input  wire logic [3:0]  addr_i,                      // Register address.
    input  wire logic [31:0] wdata_i,                     // Write data.
    input  wire logic        wr_i,                        // Write strobe.
    input  wire logic        rd_i,                        // Read strobe.
    output logic      [31:0] rdata_o,                     // Read data, one cycle later.
    output logic             invasive_ok_o,               // Invasive debug permitted.
    output logic             noninvasive_ok_o,            // Non-invasive debug permitted.
    output logic             halt_restricted_o,           // Halting with restricted capability.
    output logic             debug_state_o,               // Core held in debug state.
    output logic             debug_exception_o,           // Take debug exception pulse.
    output logic             prefetch_abort_o,            // Breakpoint turned into abort pulse.
    output logic             exception_priv_o             // Handle exception in privileged mode.
);
    // ------------------------------------------------------------------
    // Synchronised enables and permission decode.
    // ------------------------------------------------------------------
    logic [2:0] pins_sync;
    sdp_perm_if perm ();

    // The sampled view lags the pins by the synchroniser depth.
    sdp_sync u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({secure_priv_noninvasive_en_i, secure_priv_invasive_en_i,
                   global_debug_en_i}),
        .sync_o  (pins_sync)
    );

    sdp_perm u_perm (
        .p (perm.core)
    );

    // ------------------------------------------------------------------
    // State registers.
    // ------------------------------------------------------------------
    logic [1:0]  mode_sel_reg;
    logic [1:0]  mode_sel_next;
    logic [1:0]  su_bits_reg;
    logic [1:0]  su_bits_next;
    logic        dbg_state_reg;
    logic        dbg_state_next;
    logic        exc_reg;
    logic        exc_next;
    logic        pabt_reg;
    logic        pabt_next;
    logic [3:0]  last_act_reg;
    logic [3:0]  last_act_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Feed the permission decode from registers and core state.
    always_comb begin
        perm.dbg_en   = pins_sync[0];
        perm.spi_en   = pins_sync[1];
        perm.spni_en  = pins_sync[2];
        perm.sui_bit  = su_bits_reg[sdp_pkg::SUI_BIT];
        perm.suni_bit = su_bits_reg[sdp_pkg::SUNI_BIT];
        perm.ns_bit   = nonsecure_state_bit_i;
        perm.cpu_mode = cpu_mode_i;
    end

    // ------------------------------------------------------------------
    // Event decisions.
    // ------------------------------------------------------------------
    logic mode_halting;
    logic mode_monitor;
    logic permitted;

    // The stored selection is kept as written; the global enable only masks it.
    always_comb begin
        mode_halting = perm.dbg_en && mode_sel_reg[0];
        mode_monitor = perm.dbg_en && (mode_sel_reg == sdp_pkg::MODE_MONITOR);
        permitted    = perm.dbg_en && perm.inv_ok;
    end

    // Software writes steer the mode select and the secure-user bits.
    always_comb begin
        mode_sel_next = mode_sel_reg;
        su_bits_next  = su_bits_reg;
        if (wr_i && (addr_i == sdp_pkg::ADDR_STATUS_CTRL)) begin
            mode_sel_next = wdata_i[sdp_pkg::MODE_SEL_LSB +: 2];
        end
        if (wr_i && (addr_i == sdp_pkg::ADDR_SECURE_USER)) begin
            su_bits_next = wdata_i[1:0];
        end
    end

    // Each event picks one outcome; unpermitted events fall back to ignore or abort.
    always_comb begin
        dbg_state_next = dbg_state_reg;
        exc_next       = 1'b0;
        pabt_next      = 1'b0;
        last_act_next  = last_act_reg;
        if (dbg_state_reg) begin
            if (debug_exit_i) begin
                dbg_state_next = 1'b0;
            end
        end else if (permitted && (ext_debug_req_i || debug_scan_port_halt_i)) begin
            dbg_state_next = 1'b1;
            last_act_next  = sdp_pkg::SDP_ACT_HALT;
        end else if (sw_event_i || breakpoint_instruction_i) begin
            if (permitted && mode_halting) begin
                dbg_state_next = 1'b1;
                last_act_next  = sdp_pkg::SDP_ACT_HALT;
            end else if (permitted && mode_monitor) begin
                exc_next      = 1'b1;
                last_act_next = sdp_pkg::SDP_ACT_EXCEPT;
            end else if (breakpoint_instruction_i) begin
                pabt_next     = 1'b1;
                last_act_next = sdp_pkg::SDP_ACT_PABORT;
            end else begin
                last_act_next = sdp_pkg::SDP_ACT_NONE;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path: data stand in the cycle after the read strobe only.
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0;
        if (rd_i) begin
            unique case (addr_i)
                sdp_pkg::ADDR_STATUS_CTRL: begin
                    rdata_next[sdp_pkg::MODE_SEL_LSB +: 2] =
                        perm.dbg_en ? mode_sel_reg : 2'h0;
                    rdata_next[sdp_pkg::SPI_VIEW_BIT]  = perm.spi_en;
                    rdata_next[sdp_pkg::SPNI_VIEW_BIT] = perm.spni_en;
                    rdata_next[0] = dbg_state_reg;
                end
                sdp_pkg::ADDR_SECURE_USER: begin
                    rdata_next[1:0] = su_bits_reg;
                end
                sdp_pkg::ADDR_CPU_STATE: begin
                    rdata_next[2:0] = {perm.restricted, perm.noninv_ok, perm.inv_ok};
                end
                sdp_pkg::ADDR_EVENT: begin
                    rdata_next[3:0] = last_act_reg;
                end
                default: begin
                    rdata_next = 32'h0;
                end
            endcase
        end
    end

    // All state registers; async reset loads constants only.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_sel_reg  <= sdp_pkg::MODE_SEL_RST;
            su_bits_reg   <= sdp_pkg::SU_BITS_RST;
            dbg_state_reg <= 1'b0;
            exc_reg       <= 1'b0;
            pabt_reg      <= 1'b0;
            last_act_reg  <= sdp_pkg::SDP_ACT_NONE;
            rdata_reg     <= 32'h0;
        end else begin
            mode_sel_reg  <= mode_sel_next;
            su_bits_reg   <= su_bits_next;
            dbg_state_reg <= dbg_state_next;
            exc_reg       <= exc_next;
            pabt_reg      <= pabt_next;
            last_act_reg  <= last_act_next;
            rdata_reg     <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign rdata_o           = rdata_reg;
    assign invasive_ok_o     = permitted;
    assign noninvasive_ok_o  = perm.dbg_en && perm.noninv_ok;
    assign halt_restricted_o = permitted && mode_halting && perm.restricted;
    assign debug_state_o     = dbg_state_reg;
    assign debug_exception_o = exc_reg;
    assign prefetch_abort_o  = pabt_reg;
    assign exception_priv_o  = exc_reg;
endmodule

/* bench/sdp_props.sv */
module sdp_props (
    input wire logic        clk_i,                        // Core clock.
    input wire logic        rst_n_i,                      // Reset, active low.
    input wire logic        global_debug_en_i,            // Global enable pin.
    input wire logic        secure_priv_invasive_en_i,    // Secure invasive pin.
    input wire logic        secure_priv_noninvasive_en_i, // Secure non-invasive pin.
    input wire logic        nonsecure_state_bit_i,        // Non-secure state.
    input wire logic [4:0]  cpu_mode_i,                   // Processor mode.
    input wire logic        sw_event_i,                   // Software event.
    input wire logic        breakpoint_instruction_i,     // Breakpoint.
    input wire logic        ext_debug_req_i,              // External request.
    input wire logic        debug_scan_port_halt_i,       // Scan port halt.
    input wire logic        debug_exit_i,                 // Leave debug state.
    input wire logic [3:0]  addr_i,                       // Address.
    input wire logic [31:0] wdata_i,                      // Write data.
    input wire logic        wr_i,                         // Write strobe.
    input wire logic        rd_i,                         // Read strobe.
    input wire logic [31:0] rdata_o,                      // Read data.
    input wire logic        invasive_ok_o,                // Invasive verdict.
    input wire logic        noninvasive_ok_o,             // Non-invasive verdict.
    input wire logic        halt_restricted_o,            // Restricted halting.
    input wire logic        debug_state_o,                // In debug state.
    input wire logic        debug_exception_o,            // Exception pulse.
    input wire logic        prefetch_abort_o,             // Abort pulse.
    input wire logic        exception_priv_o              // Privileged handling.
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Shadow of the two-flop synchroniser and of the written fields.
    // ------------------------------------------------------------------
    logic [2:0] sy1_reg, sy2_reg;
    logic [1:0] mode_reg, mode_next, su_reg, su_next, view_w, field_w;
    logic       open_ns, sec_usr;
    // Writes are mirrored so that verdicts can be predicted exactly.
    always_comb begin
        mode_next = mode_reg;
        su_next   = su_reg;
        if (wr_i && addr_i == sdp_pkg::ADDR_STATUS_CTRL) mode_next = wdata_i[15:14];
        if (wr_i && addr_i == sdp_pkg::ADDR_SECURE_USER) su_next = wdata_i[1:0];
    end
    // The shadow lags the pins exactly as the design's synchroniser does.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sy1_reg  <= 3'h0;
            sy2_reg  <= 3'h0;
            mode_reg <= sdp_pkg::MODE_SEL_RST;
            su_reg   <= sdp_pkg::SU_BITS_RST;
        end else begin
            sy1_reg  <= {global_debug_en_i, secure_priv_invasive_en_i,
                         secure_priv_noninvasive_en_i};
            sy2_reg  <= sy1_reg;
            mode_reg <= mode_next;
            su_reg   <= su_next;
        end
    end
    assign open_ns = nonsecure_state_bit_i && cpu_mode_i != sdp_pkg::CPU_MODE_MON;
    assign sec_usr = !nonsecure_state_bit_i && cpu_mode_i == sdp_pkg::CPU_MODE_USER;
    assign view_w  = {sy2_reg[0], sy2_reg[1]};
    assign field_w = sy2_reg[2] ? mode_reg : 2'h0;
    // ------------------------------------------------------------------
    // Properties.
    // ------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_idle;
        !debug_state_o && !debug_exit_i && !ext_debug_req_i && !debug_scan_port_halt_i;
    endsequence
    sequence s_sw_only;
        s_idle ##0 sw_event_i && !breakpoint_instruction_i;
    endsequence
    a_inv_spi_high: assert property (sy2_reg[2] && sy2_reg[1] |-> invasive_ok_o)
        else $error("invasive refused with secure enable high");
    a_inv_spi_low: assert property (sy2_reg[2] && !sy2_reg[1] |->
        invasive_ok_o == (open_ns || (sec_usr && su_reg[0])))
        else $error("invasive verdict wrong with secure enable low");
    a_ninv_high: assert property (sy2_reg[2] && sy2_reg[0] |-> noninvasive_ok_o)
        else $error("non-invasive refused with enable high");
    a_ninv_low: assert property (sy2_reg[2] && !sy2_reg[0] |->
        noninvasive_ok_o == (open_ns || (sec_usr && su_reg[1])))
        else $error("non-invasive verdict wrong with enable low");
    a_all_disabled: assert property (!sy2_reg[2] |->
        !invasive_ok_o && !noninvasive_ok_o && !halt_restricted_o)
        else $error("debug permitted with global enable low");
    a_mode_readback: assert property (rd_i && addr_i == sdp_pkg::ADDR_STATUS_CTRL |=>
        rdata_o[15:14] == $past(field_w)) else $error("mode field readback wrong");
    a_status_views: assert property (rd_i && addr_i == sdp_pkg::ADDR_STATUS_CTRL |=>
        rdata_o[17:16] == $past(view_w)) else $error("secure enable views wrong");
    a_restricted_halt: assert property (halt_restricted_o == (sy2_reg[2] &&
        mode_reg[0] && !sy2_reg[1] && sec_usr && su_reg[0]))
        else $error("restricted halting flag wrong");
    a_request_entry: assert property (!debug_state_o && !debug_exit_i &&
        (ext_debug_req_i || debug_scan_port_halt_i) && invasive_ok_o |=> debug_state_o)
        else $error("permitted request did not enter debug state");
    a_breakpoint_instruction_abort: assert property (s_idle ##0 breakpoint_instruction_i &&
        (!invasive_ok_o || field_w == 2'h0) |=> prefetch_abort_o)
        else $error("breakpoint without mode did not abort");
    a_sw_ignored: assert property (s_sw_only ##0 (!invasive_ok_o || field_w == 2'h0)
        |=> !debug_state_o && !debug_exception_o) else $error("event not ignored");
    a_monitor_exc: assert property (s_sw_only ##0 invasive_ok_o &&
        field_w == sdp_pkg::MODE_MONITOR |=> debug_exception_o && exception_priv_o)
        else $error("monitor event not taken as privileged exception");
    a_halting_entry: assert property (s_sw_only ##0 invasive_ok_o && field_w[0]
        |=> debug_state_o) else $error("halting event did not enter debug state");
endmodule

bind sdp_top sdp_props u_props (.*);

/* bench/sdp_sec_ctrl.sv */
module sdp_sec_ctrl (
    input  wire logic       clk_i,   // Core clock.
    input  wire logic [2:0] want_i,  // Levels asked by system software.
    input  wire logic       slow_i,  // Apply changes after a delay.
    output logic      [2:0] pins_o   // Global, invasive, non-invasive enables.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] lag = 3'h0;
    // Pins start high so that a system without partitioning debugs by default.
    initial pins_o = 3'h7;
    // Changes land whole after an optional wait, so software must poll for them;
    // between changes the pins stand still and nothing else can drive them.
    always @(posedge clk_i) begin
        if (want_i == pins_o) lag <= slow_i ? 3'h5 : 3'h0;
        else if (lag != 3'h0) lag <= lag - 3'h1;
        else pins_o <= want_i;
    end
endmodule

/* bench/sdp_top_test.sv */
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module sdp_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        nonsecure_state_bit_i = 1'b1;
    logic [4:0]  cpu_mode_i = sdp_pkg::CPU_MODE_USER;
    logic [4:0]  ev = 5'h0;
    logic [3:0]  addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [2:0]  want = 3'h7;
    logic        slow = 1'b0;
    logic [1:0]  sel = 2'h0;
    logic [2:0]  pins, o;
    logic [31:0] rdata_o, d;
    logic        global_debug_en_i, secure_priv_invasive_en_i, secure_priv_noninvasive_en_i;
    logic        sw_event_i, breakpoint_instruction_i, ext_debug_req_i;
    logic        debug_scan_port_halt_i, debug_exit_i;
    logic        invasive_ok_o, noninvasive_ok_o, halt_restricted_o, debug_state_o;
    logic        debug_exception_o, prefetch_abort_o, exception_priv_o;
    int          err_total = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    assign {global_debug_en_i, secure_priv_invasive_en_i, secure_priv_noninvasive_en_i} = pins;
    assign {debug_exit_i, debug_scan_port_halt_i, ext_debug_req_i,
            breakpoint_instruction_i, sw_event_i} = ev;
    sdp_top uut (.*);
    sdp_sec_ctrl u_ctrl (.clk_i(clk_i), .want_i(want), .slow_i(slow), .pins_o(pins));
    // ------------------------------------------------------------------
    // Clock, watchdog and bus tasks.
    // ------------------------------------------------------------------
    always #12.5 clk_i = ~clk_i;
    // A hang is cut short well beyond the thousand or so cycles the run needs.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            close_out();
        end
    end
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just then.
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    task automatic pulse(input logic [4:0] e, output logic [2:0] r);
        @(posedge clk_i);
        ev <= e;
        @(posedge clk_i);
        ev <= 5'h0;
        #1;
        r = {prefetch_abort_o, debug_exception_o, debug_state_o};
    endtask
    // Ask for new pin levels, then poll the core's own view until it agrees.
    task automatic set_pins(input logic [2:0] v);
        logic [3:0] e;
        int         n;
        e = {v[0], v[1], v[2] ? sel : 2'h0};
        n = 0;
        want <= v;
        do begin
            rd_reg(sdp_pkg::ADDR_STATUS_CTRL, d);
            n++;
        end while (d[17:14] !== e && n < 20);
        `CHK(d[17:14], e)
    endtask
    function automatic logic [2:0] perm(input logic [2:0] p, input logic [1:0] su,
                                        input logic n, input logic [4:0] m);
        logic opn, sum;
        opn = n && m != sdp_pkg::CPU_MODE_MON;
        sum = !n && m == sdp_pkg::CPU_MODE_USER;
        perm[0] = p[2] && (p[1] || opn || (sum && su[0]));
        perm[1] = p[2] && (p[0] || opn || (sum && su[1]));
        perm[2] = p[2] && sel[0] && !p[1] && sum && su[0];
    endfunction
    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd_reg(sdp_pkg::ADDR_SECURE_USER, d);
        `CHK(d[1:0], sdp_pkg::SU_BITS_RST)
        wr_reg(4'h2, 32'hffff_ffff);
        rd_reg(4'h2, d);
        `CHK(d, 32'h0)
        wr_reg(sdp_pkg::ADDR_STATUS_CTRL, 32'h0000_4000);
        sel = 2'h1;
        $display("Register test done");
        // Every pin combination against user, monitor and supervisor modes.
        for (int p = 0; p < 8; p++) begin
            set_pins(p[2:0]);
            for (int k = 0; k < 24; k++) begin
                @(posedge clk_i);
                nonsecure_state_bit_i <= k[2];
                cpu_mode_i <= k < 8 ? sdp_pkg::CPU_MODE_USER :
                              k < 16 ? sdp_pkg::CPU_MODE_MON : 5'h13;
                wr_reg(sdp_pkg::ADDR_SECURE_USER, {30'h0, k[1:0]});
                rd_reg(sdp_pkg::ADDR_CPU_STATE, d);
                o = perm(p[2:0], k[1:0], k[2], cpu_mode_i);
                `CHK(d[2:0], o)
                `CHK({halt_restricted_o, noninvasive_ok_o, invasive_ok_o}, o)
            end
        end
        $display("Permission test done");
        wr_reg(sdp_pkg::ADDR_STATUS_CTRL, 32'h0);
        sel = 2'h0;
        pulse(5'h01, o);
        `CHK(o, 3'h0)
        pulse(5'h02, o);
        `CHK(o, 3'h4)
        rd_reg(sdp_pkg::ADDR_EVENT, d);
        `CHK(d[3:0], 4'h8)
        pulse(5'h04, o);
        `CHK(o, 3'h1)
        pulse(5'h02, o);
        `CHK(o, 3'h1)
        pulse(5'h10, o);
        `CHK(o, 3'h0)
        wr_reg(sdp_pkg::ADDR_STATUS_CTRL, 32'h0000_8000);
        pulse(5'h01, o);
        `CHK(o, 3'h2)
        `CHK(exception_priv_o, 1'b1)
        wr_reg(sdp_pkg::ADDR_STATUS_CTRL, 32'h0000_c000);
        sel = 2'h3;
        pulse(5'h01, o);
        `CHK(o, 3'h1)
        slow <= 1'b1;
        set_pins(3'h5);
        pulse(5'h10, o);
        @(posedge clk_i);
        nonsecure_state_bit_i <= 1'b0;
        cpu_mode_i <= 5'h13;
        set_pins(3'h4);
        pulse(5'h01, o);
        `CHK(o, 3'h0)
        pulse(5'h08, o);
        `CHK(o, 3'h0)
        set_pins(3'h3);
        set_pins(3'h7);
        pulse(5'h08, o);
        `CHK(o, 3'h1)
        $display("Event test done");
        close_out();
    end
endmodule
